//--- hdl/tmpc_top.sv
// What this block does
// - three-bit field picks counter clock source
// - reserved code connects no counter clock
// - compact/standard: separate P and A interrupts
// - enhanced: A, B, P each interrupt
// - match may clear counter, change pin
// - external input edge selectable rise/fall
// - external input used only when selected
// - external edges advance count as events
// - match drives pin high, low or toggle
// - pwm appears on compare output pin
// - port data bit inverts each pin
// - pin-control bit one routes pin
//
// tmpc_top: one timer core with compare P/A/B, output pins and pin control.
// assumes: AHB-Lite master on hclk; pins are synchronised inside.
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tmpc_top
  import tmpc_pkg::*;
#(
  parameter int CNT_W = 10, // counter width
  parameter int NOUT = 4, // output pins of this timer
  parameter bit ENHANCED = 1'b1 // comparator B present
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic hclk_h_en,
  input wire logic time_base_clock,
  input wire logic timer_external_input,
  input wire logic [NOUT-1:0] port_data,
  output logic [NOUT-1:0] timer_output_pin,
  output logic [NOUT-1:0] timer_output_pin_en,
  output logic ext_input_route,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl0_r; // clock select, on, edge
  logic [7:0] ctrl1_r; // action, pwm, clear source
  logic [CNT_W-1:0] cmpa_r;
  logic [CNT_W-1:0] cmpb_r;
  logic [CNT_W-1:0] cmpp_r;
  logic [7:0] pinc0_r; // timer_pin_control_0
  logic [7:0] pinc1_r; // timer_pin_control_1
  logic [TMPC_NEV-1:0] stat_r; // sticky events
  logic [TMPC_NEV-1:0] mask_r; // interrupt enables
  logic [CNT_W-1:0] cnt_r; // main counter
  logic out_r; // compare output level
  logic on_last_r; // previous on bit, for clear edge
  // bus data phase capture
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic ev_p;
  logic ev_a;
  logic ev_b;
  logic clr_match;
  logic [TMPC_NEV-1:0] ev_vec;
  logic [TMPC_NEV-1:0] w1c;
  logic [NOUT-1:0] pin_en;
  logic [CNT_W-1:0] cnt_nxt;
  tmpc_tick_if tk();

  ////////////////////////////////////////////////////////////////////////////
  // clock source selection
  tmpc_clksel u_clksel (
    .hclk(hclk),
    .hresetn(hresetn),
    .hclk_h_en(hclk_h_en),
    .sel(ctrl0_r[TMPC_CKSEL_LSB+2:TMPC_CKSEL_LSB]),
    .ext_pin(timer_external_input),
    .tbc_pin(time_base_clock),
    .tk(tk.src)
  );

  // external input pin handed to the timer only while selected
  assign ext_input_route = tk.ext_sel;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always OKAY
  function automatic logic sel_hit(input logic [7:0] a, input logic [7:0] off);
    sel_hit = (a == off);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // capture address phase of a write so the data phase can commit it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel & htrans[1] & hwrite;
      addr_r <= haddr[7:0];
    end
  end

  // read data registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (sel_hit(haddr[7:0], TMPC_CTRL0_OFF)) hrdata[7:0] <= ctrl0_r;
      if (sel_hit(haddr[7:0], TMPC_CTRL1_OFF)) hrdata[7:0] <= ctrl1_r;
      if (sel_hit(haddr[7:0], TMPC_CMPA_OFF)) hrdata[CNT_W-1:0] <= cmpa_r;
      if (sel_hit(haddr[7:0], TMPC_CMPB_OFF)) hrdata[CNT_W-1:0] <= cmpb_r;
      if (sel_hit(haddr[7:0], TMPC_CMPP_OFF)) hrdata[CNT_W-1:0] <= cmpp_r;
      if (sel_hit(haddr[7:0], TMPC_PINC0_OFF)) hrdata[7:0] <= pinc0_r;
      if (sel_hit(haddr[7:0], TMPC_PINC1_OFF)) hrdata[7:0] <= pinc1_r;
      if (sel_hit(haddr[7:0], TMPC_STAT_OFF)) hrdata[TMPC_NEV-1:0] <= stat_r;
      if (sel_hit(haddr[7:0], TMPC_MASK_OFF)) hrdata[TMPC_NEV-1:0] <= mask_r;
      if (sel_hit(haddr[7:0], TMPC_CNT_OFF)) hrdata[CNT_W-1:0] <= cnt_r;
    end
  end

  // register writes in the data phase; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_r <= 8'h00;
      ctrl1_r <= 8'h00;
      cmpa_r <= '0;
      cmpb_r <= '0;
      cmpp_r <= '0;
      pinc0_r <= TMPC_PINC0_RST;
      pinc1_r <= TMPC_PINC1_RST;
      mask_r <= '0;
    end else if (wr_pend_r) begin
      if (sel_hit(addr_r, TMPC_CTRL0_OFF)) ctrl0_r <= hwdata[7:0];
      if (sel_hit(addr_r, TMPC_CTRL1_OFF)) ctrl1_r <= hwdata[7:0];
      if (sel_hit(addr_r, TMPC_CMPA_OFF)) cmpa_r <= hwdata[CNT_W-1:0];
      if (sel_hit(addr_r, TMPC_CMPB_OFF)) cmpb_r <= hwdata[CNT_W-1:0];
      if (sel_hit(addr_r, TMPC_CMPP_OFF)) cmpp_r <= hwdata[CNT_W-1:0];
      if (sel_hit(addr_r, TMPC_PINC0_OFF)) pinc0_r <= hwdata[7:0];
      if (sel_hit(addr_r, TMPC_PINC1_OFF)) pinc1_r <= hwdata[7:0];
      if (sel_hit(addr_r, TMPC_MASK_OFF)) mask_r <= hwdata[TMPC_NEV-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparators: a match counts only on a tick, so no tick means no event
  assign ev_p = tk.tick && (cnt_nxt == cmpp_r);
  assign ev_a = tk.tick && (cnt_nxt == cmpa_r);
  assign ev_b = ENHANCED && tk.tick && (cnt_nxt == cmpb_r);
  assign ev_vec = {ev_b, ev_a, ev_p};
  assign clr_match = ctrl1_r[TMPC_CCLR_BIT] ? ev_a : ev_p;
  assign cnt_nxt = cnt_r + CNT_W'(1);

  // counter: holds without tick; cleared by on rising or the chosen match
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
      on_last_r <= 1'b0;
    end else begin
      on_last_r <= ctrl0_r[TMPC_ON_BIT];
      if (ctrl0_r[TMPC_ON_BIT] && !on_last_r) begin
        cnt_r <= '0;
      end else if (ctrl0_r[TMPC_ON_BIT] && tk.tick) begin
        cnt_r <= clr_match ? '0 : cnt_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over write-one-to-clear
  assign w1c = (wr_pend_r && sel_hit(addr_r, TMPC_STAT_OFF)) ? hwdata[TMPC_NEV-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~w1c) | (ev_vec & {TMPC_NEV{ctrl0_r[TMPC_ON_BIT]}});
    end
  end

  assign irq = |(stat_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // output pin: compare action or pwm (high below compare A, low after)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_r <= 1'b0;
    end else if (ctrl1_r[TMPC_PWM_BIT]) begin
      out_r <= (cnt_r < cmpa_r);
    end else if (ev_a && ctrl0_r[TMPC_ON_BIT]) begin
      case (tmpc_act_t'(ctrl1_r[TMPC_ACT_LSB+1:TMPC_ACT_LSB]))
        TMPC_ACT_LOW: out_r <= 1'b0;
        TMPC_ACT_HIGH: out_r <= 1'b1;
        TMPC_ACT_TGL: out_r <= ~out_r;
        default: out_r <= out_r;
      endcase
    end
  end

  // pin enables come from the pin control registers, one bit per pin
  assign pin_en = NOUT'({pinc1_r, pinc0_r});

  // each pin carries the output true or inverted by its port data bit
  genvar gi;
  generate
    for (gi = 0; gi < NOUT; gi++) begin : g_pin
      assign timer_output_pin[gi] = pin_en[gi] ? (out_r ^ port_data[gi]) : 1'b0;
      assign timer_output_pin_en[gi] = pin_en[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // counter holds when no count edge arrives and the run bit stays set
  chk_hold_no_tick: assert property (@(posedge hclk) disable iff (!hresetn)
    (!tk.tick && $past(ctrl0_r[TMPC_ON_BIT]) && ctrl0_r[TMPC_ON_BIT]) |=> $stable(cnt_r))
    else $error("counter moved without a tick");
  // reserved selection: no match event can be raised at all
  chk_rsvd_no_event: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl0_r[TMPC_CKSEL_LSB+2:TMPC_CKSEL_LSB] == TMPC_CK_RSVD |-> ev_vec == '0)
    else $error("match event without a clock");
  // an accepted edge advances the count by one unless a match clears it
  chk_count_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (tk.tick && ctrl0_r[TMPC_ON_BIT] && on_last_r && !clr_match) |=> cnt_r == $past(cnt_nxt))
    else $error("count edge not applied");
  // a rising run bit restarts the count from zero
  chk_on_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl0_r[TMPC_ON_BIT] && !on_last_r) |=> cnt_r == '0)
    else $error("run bit rise did not clear counter");
  // each comparator sets its own status bit, even against a same-cycle clear
  chk_match_p_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev_p && ctrl0_r[TMPC_ON_BIT]) |=> stat_r[TMPC_EV_P])
    else $error("match p did not set status");
  chk_match_a_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev_a && ctrl0_r[TMPC_ON_BIT]) |=> stat_r[TMPC_EV_A])
    else $error("match a did not set status");
  chk_match_b_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev_b && ctrl0_r[TMPC_ON_BIT]) |=> stat_r[TMPC_EV_B])
    else $error("match b did not set status");
  // a stopped counter raises no new status bits
  chk_off_no_set: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl0_r[TMPC_ON_BIT] |=> (stat_r & ~$past(stat_r)) == '0)
    else $error("status set while stopped");
  // write-one-to-clear lands when no event competes for the same bit
  chk_w1c_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (w1c & ev_vec) == '0 |=> (stat_r & $past(w1c)) == '0)
    else $error("status bit not cleared");
  // interrupt line is a pure level of pending and enabled bits
  chk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat_r & mask_r) != '0 |-> irq) else $error("irq low with pending event");
  chk_irq_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat_r & mask_r) == '0 |-> !irq) else $error("irq high with nothing pending");
  // the chosen match wraps the counter to zero
  chk_match_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (clr_match && ctrl0_r[TMPC_ON_BIT] && on_last_r) |=> cnt_r == '0)
    else $error("match did not clear counter");
  // output actions on a match of comparator a, pwm off
  chk_toggle_act: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev_a && ctrl0_r[TMPC_ON_BIT] && !ctrl1_r[TMPC_PWM_BIT]
     && ctrl1_r[TMPC_ACT_LSB+1:TMPC_ACT_LSB] == TMPC_ACT_TGL) |=> out_r != $past(out_r))
    else $error("toggle action missed");
  chk_high_act: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev_a && ctrl0_r[TMPC_ON_BIT] && !ctrl1_r[TMPC_PWM_BIT]
     && ctrl1_r[TMPC_ACT_LSB+1:TMPC_ACT_LSB] == TMPC_ACT_HIGH) |=> out_r)
    else $error("high action missed");
  chk_low_act: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev_a && ctrl0_r[TMPC_ON_BIT] && !ctrl1_r[TMPC_PWM_BIT]
     && ctrl1_r[TMPC_ACT_LSB+1:TMPC_ACT_LSB] == TMPC_ACT_LOW) |=> !out_r)
    else $error("low action missed");
  chk_none_act: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev_a && ctrl0_r[TMPC_ON_BIT] && !ctrl1_r[TMPC_PWM_BIT]
     && ctrl1_r[TMPC_ACT_LSB+1:TMPC_ACT_LSB] == TMPC_ACT_NONE) |=> $stable(out_r))
    else $error("idle action moved the pin");
  // pwm level follows count below compare a, one cycle later
  chk_pwm_level: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl1_r[TMPC_PWM_BIT] |=> out_r == ($past(cnt_r) < $past(cmpa_r)))
    else $error("pwm level wrong");
  // pin polarity and routing
  chk_pin_invert: assert property (@(posedge hclk) disable iff (!hresetn)
    pin_en[0] |-> timer_output_pin[0] == (out_r ^ port_data[0]))
    else $error("pin polarity wrong");
  chk_pin_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (timer_output_pin & ~pin_en) == '0) else $error("disabled pin driven high");
  chk_route_out: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_input_route |-> ctrl0_r[TMPC_CKSEL_LSB+2:TMPC_CKSEL_LSB+1] == 2'b11)
    else $error("input routed while not selected");
  // register writes land at the end of the data phase
  chk_ctrl0_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_r == TMPC_CTRL0_OFF) |=> ctrl0_r == 8'($past(hwdata)))
    else $error("control write lost");
  chk_cmpa_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_r == TMPC_CMPA_OFF) |=> cmpa_r == CNT_W'($past(hwdata)))
    else $error("compare write lost");
  chk_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_r == TMPC_MASK_OFF) |=> mask_r == TMPC_NEV'($past(hwdata)))
    else $error("mask write lost");
  cov_match_a: cover property (@(posedge hclk) disable iff (!hresetn) ev_a ##1 irq);
  cov_pwm: cover property (@(posedge hclk) disable iff (!hresetn)
    ctrl1_r[TMPC_PWM_BIT] && $fell(out_r));
  cov_set_clear: cover property (@(posedge hclk) disable iff (!hresetn) |(ev_vec & w1c));
endmodule
`default_nettype wire

//--- common/tmpc_pkg.sv
// tmpc_pkg: register map, field layout, clock select codes and modes for the
// shared timer core with pin control.
// assumes: a 32-bit AHB-Lite register bus, one clock domain.
package tmpc_pkg;
  // byte offsets of the word registers
  localparam logic [7:0] TMPC_CTRL0_OFF = 8'h00; // timer_control_reg0
  localparam logic [7:0] TMPC_CTRL1_OFF = 8'h04; // output action, mode, clear source
  localparam logic [7:0] TMPC_CMPA_OFF = 8'h08; // compare_a_value
  localparam logic [7:0] TMPC_CMPB_OFF = 8'h0c; // compare b value
  localparam logic [7:0] TMPC_CMPP_OFF = 8'h10; // compare_p_value
  localparam logic [7:0] TMPC_PINC0_OFF = 8'h14; // timer_pin_control_0
  localparam logic [7:0] TMPC_PINC1_OFF = 8'h18; // timer_pin_control_1
  localparam logic [7:0] TMPC_STAT_OFF = 8'h1c; // sticky events, w1c
  localparam logic [7:0] TMPC_MASK_OFF = 8'h20; // interrupt mask
  localparam logic [7:0] TMPC_CNT_OFF = 8'h24; // counter, read only
  // control 0 fields
  localparam int TMPC_CKSEL_LSB = 4; // clock_select_field bits 6:4
  localparam int TMPC_ON_BIT = 3; // counter run; rising edge clears counter
  localparam int TMPC_EDGE_BIT = 0; // external input edge, not read; clock select codes 6 and 7 pick rise or fall
  // control 1 fields
  localparam int TMPC_ACT_LSB = 4; // output action bits 5:4
  localparam int TMPC_PWM_BIT = 3; // 1 = pwm on output pin
  localparam int TMPC_CCLR_BIT = 0; // 1 = clear on match a, 0 = on match p
  // pin control reset values
  localparam logic [7:0] TMPC_PINC0_RST = 8'h91;
  localparam logic [7:0] TMPC_PINC1_RST = 8'h11;
  // status bit positions
  localparam int TMPC_EV_P = 0;
  localparam int TMPC_EV_A = 1;
  localparam int TMPC_EV_B = 2;
  localparam int TMPC_NEV = 3;
  // clock selection codes
  typedef enum logic [2:0] {
    TMPC_CK_SYS4 = 3'h0, TMPC_CK_H = 3'h1, TMPC_CK_H16 = 3'h2, TMPC_CK_H64 = 3'h3,
    TMPC_CK_TBC = 3'h4, TMPC_CK_RSVD = 3'h5, TMPC_CK_EXTR = 3'h6, TMPC_CK_EXTF = 3'h7
  } tmpc_cksel_t;
  // compare match output actions
  typedef enum logic [1:0] {
    TMPC_ACT_NONE = 2'h0, TMPC_ACT_LOW = 2'h1, TMPC_ACT_HIGH = 2'h2, TMPC_ACT_TGL = 2'h3
  } tmpc_act_t;
  // prescaler divide counts
  localparam int TMPC_DIV_SYS = 4;
  localparam int TMPC_DIV_H16 = 16;
  localparam int TMPC_DIV_H64 = 64;
endpackage

//--- common/tmpc_tick_if.sv
// tmpc_tick_if: count tick and external input select passed from clock select to core.
// assumes: one clock domain; tick is a one-cycle pulse, ext_sel a level.
`timescale 1ns/1ps
`default_nettype none
interface tmpc_tick_if;
  logic tick; // one count edge
  logic ext_sel; // external input chosen
  modport src (output tick, output ext_sel);
  modport dst (input tick, input ext_sel);
endinterface
`default_nettype wire

//--- hdl/tmpc_clksel.sv
// tmpc_clksel: turns the chosen clock source into one-cycle count ticks.
// assumes: ext and tbc inputs are asynchronous pins, synchronised here.
`timescale 1ns/1ps
`default_nettype none
module tmpc_clksel
  import tmpc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hclk_h_en,
  input wire logic [2:0] sel,
  input wire logic ext_pin,
  input wire logic tbc_pin,
  tmpc_tick_if.src tk
);
  logic [1:0] ext_sync_r; // two-flop synchroniser for the external input
  logic [1:0] tbc_sync_r; // two-flop synchroniser for the time base
  logic ext_last_r; // previous synced level, for edge detect
  logic tbc_last_r;
  logic [5:0] pre_r; // free prescaler on the high clock enable
  logic rise_ext;
  logic fall_ext;
  logic rise_tbc;

  // synchronisers: first stage is read only by the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sync_r <= 2'h0;
      tbc_sync_r <= 2'h0;
      ext_last_r <= 1'b0;
      tbc_last_r <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[0], ext_pin};
      tbc_sync_r <= {tbc_sync_r[0], tbc_pin};
      ext_last_r <= ext_sync_r[1];
      tbc_last_r <= tbc_sync_r[1];
    end
  end

  // prescaler advances on every high clock enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 6'h0;
    end else if (hclk_h_en) begin
      pre_r <= pre_r + 6'h1;
    end
  end

  assign rise_ext = ext_sync_r[1] & ~ext_last_r;
  assign fall_ext = ~ext_sync_r[1] & ext_last_r;
  assign rise_tbc = tbc_sync_r[1] & ~tbc_last_r;

  // source mux; the system divider reuses pre_r low bits
  always_comb begin
    tk.tick = 1'b0;
    tk.ext_sel = 1'b0;
    case (tmpc_cksel_t'(sel))
      TMPC_CK_SYS4: tk.tick = (pre_r[1:0] == 2'(TMPC_DIV_SYS - 1)) & hclk_h_en;
      TMPC_CK_H: tk.tick = hclk_h_en;
      TMPC_CK_H16: tk.tick = hclk_h_en & (pre_r[3:0] == 4'(TMPC_DIV_H16 - 1));
      TMPC_CK_H64: tk.tick = hclk_h_en & (pre_r == 6'(TMPC_DIV_H64 - 1));
      TMPC_CK_TBC: tk.tick = rise_tbc;
      TMPC_CK_RSVD: tk.tick = 1'b0; // no clock connected
      TMPC_CK_EXTR: begin
        tk.ext_sel = 1'b1;
        tk.tick = rise_ext; // each active edge counts
      end
      TMPC_CK_EXTF: begin
        tk.ext_sel = 1'b1;
        tk.tick = fall_ext;
      end
      default: tk.tick = 1'b0;
    endcase
  end

  // covers: external edges counted, reserved selection idle
  cov_ext_tick: cover property (@(posedge hclk) disable iff (!hresetn) tk.ext_sel && tk.tick);
  cov_rsvd: cover property (@(posedge hclk) disable iff (!hresetn) sel == TMPC_CK_RSVD);
  chk_reserved_no_tick: assert property (@(posedge hclk) disable iff (!hresetn)
    sel == TMPC_CK_RSVD |-> !tk.tick) else $error("tick under reserved select");
  chk_ext_route: assert property (@(posedge hclk) disable iff (!hresetn)
    tk.ext_sel |-> sel[2] && sel[1]) else $error("ext routed when unselected");
  // edge detect is combinational: the tick stands in the cycle the synced level moves
  chk_ext_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (sel == TMPC_CK_EXTR && $rose(ext_sync_r[1])) |-> tk.tick)
    else $error("rising ext edge not counted");
  chk_ext_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    (sel == TMPC_CK_EXTF && $fell(ext_sync_r[1])) |-> tk.tick)
    else $error("falling ext edge not counted");
endmodule
`default_nettype wire

//--- testbench/tmpc_partner.sv
// tmpc_partner: far side of the timer, making edges on the external input pin
// and on the time base pin.
// assumes: called right after a rising hclk edge; pins are levels, never released.
`timescale 1ns/1ps
`default_nettype none
module tmpc_partner (
  input wire logic hclk,
  output logic ext_pin,
  output logic tbc_pin
);
  ////////////////////////////////////////////////////////////////////////////
  // both pins rest low until the first burst
  initial begin
    ext_pin = 1'b0;
    tbc_pin = 1'b0;
  end

  // n active edges of the asked polarity, ending on the active level
  // hold of 4..8 cycles: slower than the 2-flop sync, sometimes prompt, sometimes slow
  task automatic edges(input bit use_tbc, input bit rise, input int n);
    int hold;
    for (int i = 0; i < 2 * n; i++) begin
      hold = 4 + $urandom % 5;
      // even steps go to the idle level, odd steps make the active edge
      if (use_tbc) begin
        tbc_pin <= (i % 2 == 1) ~^ rise;
      end else begin
        ext_pin <= (i % 2 == 1) ~^ rise;
      end
      repeat (hold) @(posedge hclk);
    end
  endtask
endmodule
`default_nettype wire

//--- testbench/tmpc_top_tb.sv
// tmpc_top_tb: self-checking bench for the timer core with pin control.
// assumes: hreadyout feeds hready; tmpc_partner makes the input pin edges.
`timescale 1ns/1ps
`default_nettype none
module tmpc_top_tb import tmpc_pkg::*; ;
  typedef struct packed {logic [1:0] src; logic [31:0] v;} tmpc_note_t;
  logic hclk, hresetn, hsel, hwrite, hclk_h_en, look_r, rd_dphase;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] port_data, pins, pin_en;
  logic hreadyout, hresp, irq, route, ext_pin, tbc_pin;
  int miscompares, checks_done;
  tmpc_note_t exp_q[$]; // expected results, oldest first

  tmpc_top #(.CNT_W(10), .NOUT(4), .ENHANCED(1'b1)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hclk_h_en(hclk_h_en),
    .time_base_clock(tbc_pin), .timer_external_input(ext_pin), .port_data(port_data),
    .timer_output_pin(pins), .timer_output_pin_en(pin_en), .ext_input_route(route),
    .irq(irq)
  );
  tmpc_partner pt (.hclk(hclk), .ext_pin(ext_pin), .tbc_pin(tbc_pin));

  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one single transfer; a read notes its expected word before the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0000_00, a};
    if (!wr) exp_q.push_back({2'd0, d});
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0000_0000;
    rd_dphase <= !wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dphase <= 1'b0;
  endtask

  // note a pin level expectation: 1 pins, 2 pin enables, 3 {hresp, irq, route}
  task automatic look(input logic [1:0] src, input logic [31:0] v);
    exp_q.push_back({src, v});
    look_r <= 1'b1;
    @(posedge hclk);
    look_r <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watcher: takes the oldest note whenever a read or a look lands
  always @(posedge hclk) begin
    tmpc_note_t n;
    logic [31:0] seen;
    if (rd_dphase || look_r) begin
      n = exp_q.pop_front();
      case (n.src)
        2'd0: seen = hrdata;
        2'd1: seen = {28'h000_0000, pins};
        2'd2: seen = {28'h000_0000, pin_en};
        default: seen = {29'h0, hresp, irq, route};
      endcase
      check(seen, n.v);
    end
  end

  // watchdog: the whole run needs well under 1500 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int n;
    int d;
    logic [2:0] code;
    logic [3:0] pd;
    logic [1:0] act;
    logic o;
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; hclk_h_en = 1'b1; port_data = 4'h0;
    look_r = 1'b0; rd_dphase = 1'b0; miscompares = 0; checks_done = 0;
    void'($urandom(25));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, unmapped and read-only places
    bus(0, TMPC_PINC0_OFF, 32'h0000_0091);
    bus(0, TMPC_PINC1_OFF, 32'h0000_0011);
    look(2, 32'h0000_0001);
    bus(1, 8'h40, $urandom);
    bus(1, TMPC_CNT_OFF, $urandom);
    bus(0, 8'h40, 32'h0000_0000);
    bus(0, TMPC_CNT_OFF, 32'h0000_0000);
    // interrupts: all three comparators on the hclk rate clock
    bus(1, TMPC_CMPA_OFF, 32'h0000_0005);
    bus(1, TMPC_CMPB_OFF, 32'h0000_0007);
    bus(1, TMPC_CMPP_OFF, 32'h0000_000a);
    bus(1, TMPC_CTRL0_OFF, 32'h0000_0018);
    repeat (40) @(posedge hclk);
    bus(1, TMPC_CTRL0_OFF, 32'h0000_0010);
    bus(0, TMPC_STAT_OFF, 32'h0000_0007);
    look(3, 32'h0000_0000);
    bus(1, TMPC_MASK_OFF, 32'h0000_0002);
    look(3, 32'h0000_0002);
    bus(1, TMPC_STAT_OFF, 32'h0000_0002);
    bus(0, TMPC_STAT_OFF, 32'h0000_0005);
    look(3, 32'h0000_0000);
    bus(1, TMPC_MASK_OFF, 32'h0000_0004);
    look(3, 32'h0000_0002);
    bus(1, TMPC_STAT_OFF, 32'h0000_0007);
    look(3, 32'h0000_0000);
    bus(1, TMPC_MASK_OFF, 32'h0000_0000);
    // pin and time base clocks: exact edge counts, no match reached
    bus(1, TMPC_CMPA_OFF, 32'h0000_03ff);
    bus(1, TMPC_CMPB_OFF, 32'h0000_03ff);
    bus(1, TMPC_CMPP_OFF, 32'h0000_03ff);
    for (int k = 0; k < 4; k++) begin
      code = (k == 0) ? TMPC_CK_EXTR : (k == 1) ? TMPC_CK_EXTF :
             (k == 2) ? TMPC_CK_TBC : TMPC_CK_RSVD;
      n = 3 + $urandom % 6;
      bus(1, TMPC_CTRL0_OFF, {25'h0, code, 4'h0});
      bus(1, TMPC_CTRL0_OFF, {25'h0, code, 4'h8});
      look(3, {31'h0, code[2] & code[1]});
      pt.edges(k == 2, k != 1, n);
      repeat (8) @(posedge hclk);
      bus(0, TMPC_CNT_OFF, (k == 3) ? 32'h0 : n);
    end
    // divided clocks: d*m counted edges hold exactly m ticks, whatever the prescaler phase
    for (int k = 0; k < 3; k++) begin
      code = (k == 0) ? TMPC_CK_SYS4 : (k == 1) ? TMPC_CK_H16 : TMPC_CK_H64;
      d = (k == 0) ? TMPC_DIV_SYS : (k == 1) ? TMPC_DIV_H16 : TMPC_DIV_H64;
      n = 1 + $urandom % 4;
      bus(1, TMPC_CTRL0_OFF, {25'h0, code, 4'h0});
      bus(1, TMPC_CTRL0_OFF, {25'h0, code, 4'h8});
      repeat (d * n - 1) @(posedge hclk);
      bus(1, TMPC_CTRL0_OFF, {25'h0, code, 4'h0});
      bus(0, TMPC_CNT_OFF, n);
    end
    bus(0, TMPC_STAT_OFF, 32'h0000_0000);
    // output actions on pins 0 and 2, pins 1 and 3 left to their other use
    bus(1, TMPC_PINC0_OFF, 32'h0000_0095); // output pins 0 and 2 here; the timer input still clocks the count
    look(2, 32'h0000_0005);
    bus(1, TMPC_CMPA_OFF, 32'h0000_0002);
    for (int k = 0; k < 5; k++) begin
      act = (k == 0) ? TMPC_ACT_HIGH : (k == 1) ? TMPC_ACT_LOW : TMPC_ACT_TGL;
      o = (k != 1) && (k != 4);
      pd = $urandom;
      port_data <= pd;
      // step 3 is pwm: high while count is below compare a
      if (k == 3) bus(1, TMPC_CTRL1_OFF, 32'h0000_0008);
      else if (k < 3) bus(1, TMPC_CTRL1_OFF, {26'h0, act, 3'h0, k == 2});
      if (k != 4) bus(1, TMPC_CTRL0_OFF, 32'h0000_0060);
      if (k != 4) bus(1, TMPC_CTRL0_OFF, 32'h0000_0068);
      if (k != 3) pt.edges(0, 1, 3);
      repeat (8) @(posedge hclk);
      look(1, {28'h0, ({4{o}} ^ pd) & 4'h5});
      if (k < 3) bus(0, TMPC_CNT_OFF, (k == 2) ? 32'h1 : 32'h3);
    end
    repeat (2) @(posedge hclk);
    close_out();
  end
endmodule
`default_nettype wire
